/* logic/pts_crc8.sv */
// One byte step of the reflected Ethernet frame check sequence
`timescale 1ns/100ps
`default_nettype none
module pts_crc8
  import pts_pkg::*;
(
  // Running value and data byte
  input wire logic [31:0] crc_i,
  input wire logic [7:0] data_i,
  // Updated value
  output logic [31:0] crc_o
);

  always_comb begin
    logic [31:0] c;
    c = crc_i ^ {24'h000000, data_i};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end

endmodule : pts_crc8
`default_nettype wire

/* logic/pts_pkg.sv */
// Shared constants and types for the transmit one-step timestamp block
package pts_pkg;

  // Management register placement
  localparam logic [2:0] REG_PAGE_CFG = 3'h5;
  localparam logic [4:0] REG_ADDR_TXCFG = 5'h16;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] CFG_WR_MASK = 16'hBFFF;

  // Frame parsing offsets, counted from the first destination address byte
  localparam logic [10:0] ETYPE_LO = 11'h00D;
  localparam logic [10:0] PROTO_V4 = 11'h017;
  localparam logic [10:0] PROTO_V6 = 11'h014;
  localparam logic [10:0] DST_V4 = 11'h01E;
  localparam logic [10:0] DST_V4_END = 11'h021;
  localparam logic [10:0] DST_V6 = 11'h026;
  localparam logic [10:0] DST_V6_END = 11'h035;
  localparam logic [10:0] BASE_L2 = 11'h00E;
  localparam logic [10:0] BASE_V4 = 11'h02A;
  localparam logic [10:0] BASE_V6 = 11'h03E;
  localparam logic [10:0] PORT_BACK = 11'h005;
  localparam logic [10:0] CNT_MAX = 11'h7FF;

  // Offsets inside the event message
  localparam logic [10:0] OFF_VER = 11'h001;
  localparam logic [10:0] OFF_FLAGS = 11'h006;
  localparam logic [10:0] OFF_CAP = 11'h007;
  localparam logic [10:0] OFF_TS = 11'h022;
  localparam logic [10:0] TS_BYTES = 11'h00A;
  localparam int FLAG_TWO_STEP = 1;
  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DREQ = 4'h1;
  localparam logic [3:0] MSG_NONE = 4'hF;

  // Field values
  localparam logic [15:0] ETYPE_L2 = 16'h88F7;
  localparam logic [15:0] ETYPE_V4 = 16'h0800;
  localparam logic [15:0] ETYPE_V6 = 16'h86DD;
  localparam logic [7:0] IP_UDP = 8'h11;
  localparam logic [7:0] V4_MCAST_HI = 8'hE0;
  localparam logic [7:0] V4_MCAST_NEXT = 8'h00;
  localparam logic [7:0] V6_MCAST_HI = 8'hFF;
  localparam logic [15:0] TAIL_PTP_PRI = 16'h0181;
  localparam logic [15:0] TAIL_PTP_PEER = 16'h006B;
  localparam logic [15:0] TAIL_NTP = 16'h0101;
  localparam logic [15:0] PORT_PTP = 16'h013F;
  localparam logic [15:0] PORT_NTP = 16'h007B;

  // Output path timing and check sequence
  localparam logic [2:0] DLY = 3'h6;
  localparam logic [2:0] FIX_BYTES = 3'h2;
  localparam logic [2:0] DRAIN_LAST = 3'h5;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  typedef struct packed {
    logic sync_one_step_enable;
    logic rsvd;
    logic delay_request_stamp_insert;
    logic ntp_port_select;
    logic ignore_two_step_flag;
    logic pass_valid_crc_on_insert;
    logic udp_checksum_fixup;
    logic iana_destination_filter;
    logic layer2_detect_enable;
    logic ipv6_detect_enable;
    logic ipv4_detect_enable;
    logic [3:0] transmit_version_match;
    logic transmit_stamp_enable;
  } pts_cfg_s;

  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] ns;
  } pts_time_s;

  typedef enum logic [1:0] {ENC_NONE, ENC_L2, ENC_V4, ENC_V6} pts_enc_e;
  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DRAIN} pts_st_e;

endpackage : pts_pkg

/* logic/pts_tx_stamp.sv */
// Transmit one-step timestamp insertion with checksum and check sequence repair
// How it works
// - Sync frames get transmit time inserted
// - Modified frames get regenerated check sequence
// - Stored Delay_Req time offered to receive insertion
// - Newest Delay_Req time replaces older one
// - Delay_Resp insertion needs receive insertion enabled
// - Match UDP port 319, or 123 for NTP
// - Port choice drives transmit and receive parsers
// - Two_Step flag blocks insertion unless ignored
// - Bad incoming check sequence stays bad unless disabled
// - Checksum fixup rewrites last two payload bytes
// - Fixup never touches Layer2 frames
// - Optional filter on assigned IP destinations
// - Reserved bit ignores writes, reads zero
// - Capture only with transmit stamping enabled
// - Version match, zero disables the check
// - Separate Layer2, IPv6, IPv4 detection enables
`timescale 1ns/100ps
`default_nettype none
module pts_tx_stamp
  import pts_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // Management register port
  input wire logic [2:0] REG_PAGE_I,
  input wire logic [4:0] REG_ADDR_I,
  input wire logic REG_WE_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  // Byte stream from the MAC
  input wire logic TX_EN_I,
  input wire logic [7:0] TXD_I,
  // Byte stream toward the line
  output logic TX_EN_O,
  output logic [7:0] TXD_O,
  // Local time
  input wire pts_time_s TIME_I,
  // Timestamp capture
  output logic TX_STAMP_VALID_O,
  output pts_time_s TX_STAMP_O,
  // Receive side coupling
  input wire logic RX_STAMP_INSERT_EN_I,
  output logic DELAY_RESP_INSERT_O,
  output pts_time_s DELAY_REQ_STAMP_O,
  output logic NTP_PORT_SELECT_O
);

  typedef struct packed {
    pts_st_e st;
    pts_cfg_s cfg;
    pts_cfg_s fcfg;
    logic [15:0] rdata;
    logic [10:0] cnt;
    logic [10:0] base;
    pts_enc_e enc;
    logic [7:0] hold;
    logic ok;
    logic dmatch;
    logic [3:0] msg;
    logic [3:0] ver;
    logic two;
    logic ins;
    logic [7:0] sv_new;
    logic [7:0] sv_old;
    logic [15:0] csum;
    logic [31:0] crc_in;
    logic [31:0] crc_out;
    logic [5:0][7:0] dly;
    logic [2:0] fill;
    logic [2:0] k;
    logic tx_en;
    logic [7:0] txd;
    logic stamp_v;
    pts_time_s ts;
    pts_time_s stamp;
    pts_time_s dreq;
    logic dr_ins;
    logic ntp;
  } pts_state_s;

  pts_state_s q;
  pts_state_s n;
  logic emit;
  logic draining;
  logic [2:0] kk;
  logic [7:0] e;
  logic [31:0] crc_in_nx;
  logic [31:0] crc_out_nx;
  logic [31:0] crc_in_seed;

  function automatic logic reg_hit(input logic [2:0] pg, input logic [4:0] ad);
    return (pg == REG_PAGE_CFG) && (ad == REG_ADDR_TXCFG);
  endfunction : reg_hit

  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc_add

  function automatic logic [7:0] ts_byte(input pts_time_s t, input logic [3:0] idx);
    logic [79:0] v;
    v = t << {idx, 3'b000};
    return v[79:72];
  endfunction : ts_byte

  function automatic logic iana_tail(input logic [15:0] tail, input logic ntp);
    return ntp ? (tail == TAIL_NTP) : (tail == TAIL_PTP_PRI || tail == TAIL_PTP_PEER);
  endfunction : iana_tail

  assign crc_in_seed = (q.st == ST_IDLE) ? CRC_INIT : q.crc_in;

  pts_crc8 u_crc_in (
    .crc_i(crc_in_seed),
    .data_i(TXD_I),
    .crc_o(crc_in_nx)
  );

  pts_crc8 u_crc_out (
    .crc_i(q.crc_out),
    .data_i(e),
    .crc_o(crc_out_nx)
  );

  // Output byte: six bytes behind the input so the tail can be rewritten
  always_comb begin
    logic [31:0] fcs;
    logic [1:0] idx;
    fcs = ~q.crc_out;
    draining = (q.st == ST_DRAIN) || (q.st == ST_FRAME && !TX_EN_I);
    kk = (q.st == ST_DRAIN) ? q.k : 3'h0;
    // Byte select of the check sequence must follow the drain count of this cycle
    idx = 2'(kk - FIX_BYTES);
    emit = draining || (q.st == ST_FRAME && q.fill == DLY);
    e = q.dly[5];
    if (draining && q.ins) begin
      if (kk < FIX_BYTES) begin
        if (q.fcfg.udp_checksum_fixup && q.enc != ENC_L2) begin
          e = (kk == 3'h0) ? ~q.csum[15:8] : ~q.csum[7:0];
        end
      end else begin
        e = fcs[{idx, 3'b000} +: 8];
        if (kk == FIX_BYTES && q.crc_in != CRC_RESIDUE && !q.fcfg.pass_valid_crc_on_insert) begin
          e = e ^ 8'hFF;
        end
      end
    end
  end

  always_comb begin
    logic [10:0] rel;
    logic [3:0] tk;
    logic [7:0] m;
    logic ip;
    logic evt;
    n = q;
    rel = q.cnt - q.base;
    tk = 4'(rel - OFF_TS);
    m = TXD_I;
    ip = (q.enc == ENC_V4) || (q.enc == ENC_V6);
    evt = 1'b0;
    n.hold = TXD_I;
    n.stamp_v = 1'b0;
    n.dr_ins = q.cfg.delay_request_stamp_insert & RX_STAMP_INSERT_EN_I;
    n.ntp = q.cfg.ntp_port_select;
    n.rdata = reg_hit(REG_PAGE_I, REG_ADDR_I) ? q.cfg : CFG_RST;
    if (REG_WE_I && reg_hit(REG_PAGE_I, REG_ADDR_I)) begin
      n.cfg = pts_cfg_s'(REG_WDATA_I & CFG_WR_MASK);
    end
    n.tx_en = emit;
    n.txd = emit ? e : 8'h00;
    if (emit && !(draining && kk >= FIX_BYTES)) begin
      n.crc_out = crc_out_nx;
    end
    case (q.st)
      ST_IDLE: begin
        if (TX_EN_I) begin
          n.st = ST_FRAME;
          n.fcfg = q.cfg;
          n.ts = TIME_I;
          n.cnt = 11'h001;
          n.base = 11'h000;
          n.enc = ENC_NONE;
          n.ok = 1'b1;
          n.dmatch = 1'b1;
          n.msg = MSG_NONE;
          n.ver = 4'h0;
          n.two = 1'b0;
          n.ins = 1'b0;
          n.csum = 16'h0000;
          n.crc_in = crc_in_nx;
          n.crc_out = CRC_INIT;
          n.dly = {q.dly[4:0], TXD_I};
          n.fill = 3'h1;
        end
      end
      ST_FRAME, ST_DRAIN: begin
        if (!draining) begin
          n.crc_in = crc_in_nx;
          n.cnt = (q.cnt == CNT_MAX) ? q.cnt : q.cnt + 11'h001;
          if (q.fill != DLY) begin
            n.fill = q.fill + 3'h1;
          end
          if (q.cnt == ETYPE_LO) begin
            n.ok = 1'b0;
            if ({q.hold, TXD_I} == ETYPE_L2 && q.fcfg.layer2_detect_enable) begin
              n.enc = ENC_L2;
              n.base = BASE_L2;
              n.ok = 1'b1;
            end
            if ({q.hold, TXD_I} == ETYPE_V4 && q.fcfg.ipv4_detect_enable) begin
              n.enc = ENC_V4;
              n.base = BASE_V4;
              n.ok = 1'b1;
            end
            if ({q.hold, TXD_I} == ETYPE_V6 && q.fcfg.ipv6_detect_enable) begin
              n.enc = ENC_V6;
              n.base = BASE_V6;
              n.ok = 1'b1;
            end
          end
          if ((q.enc == ENC_V4 && q.cnt == PROTO_V4) || (q.enc == ENC_V6 && q.cnt == PROTO_V6)) begin
            if (TXD_I != IP_UDP) begin
              n.ok = 1'b0;
            end
          end
          // Destination prefix and tail against the assigned multicast groups
          if ((q.enc == ENC_V4 && q.cnt == DST_V4 && TXD_I != V4_MCAST_HI) ||
              (q.enc == ENC_V4 && q.cnt == DST_V4 + 11'h001 && TXD_I != V4_MCAST_NEXT) ||
              (q.enc == ENC_V6 && q.cnt == DST_V6 && TXD_I != V6_MCAST_HI)) begin
            n.dmatch = 1'b0;
          end
          if ((q.enc == ENC_V4 && q.cnt == DST_V4_END) || (q.enc == ENC_V6 && q.cnt == DST_V6_END)) begin
            if (!iana_tail({q.hold, TXD_I}, q.fcfg.ntp_port_select)) begin
              n.dmatch = 1'b0;
            end
          end
          if (ip && q.cnt == q.base - PORT_BACK) begin
            if ({q.hold, TXD_I} != (q.fcfg.ntp_port_select ? PORT_NTP : PORT_PTP)) begin
              n.ok = 1'b0;
            end
          end
          if (q.enc != ENC_NONE && q.cnt >= q.base) begin
            if (rel == 11'h000) begin
              n.msg = TXD_I[3:0];
            end
            if (rel == OFF_VER) begin
              n.ver = TXD_I[3:0];
              if (q.fcfg.transmit_version_match != 4'h0 && TXD_I[3:0] != q.fcfg.transmit_version_match) begin
                n.ok = 1'b0;
              end
            end
            if (rel == OFF_FLAGS) begin
              n.two = TXD_I[FLAG_TWO_STEP];
            end
            if (rel == OFF_CAP) begin
              evt = q.ok && q.fcfg.transmit_stamp_enable && (!ip || !q.fcfg.iana_destination_filter || q.dmatch);
              if (evt) begin
                n.stamp_v = 1'b1;
                n.stamp = q.ts;
                if (q.msg == MSG_DREQ) begin
                  n.dreq = q.ts;
                end
              end
              n.ins = evt && q.fcfg.sync_one_step_enable && q.msg == MSG_SYNC &&
                      (q.fcfg.ignore_two_step_flag || !q.two);
            end
            if (q.ins && rel >= OFF_TS && rel < OFF_TS + TS_BYTES) begin
              m = ts_byte(q.ts, tk);
              if (!tk[0]) begin
                n.sv_new = m;
                n.sv_old = TXD_I;
              end else begin
                n.csum = oc_add(oc_add(q.csum, {q.sv_new, m}), ~{q.sv_old, TXD_I});
              end
            end
          end
          n.dly = {q.dly[4:0], m};
        end else begin
          // Byte-wide stream gives the drain no way to stall; frames under six bytes are not supported
          n.dly = {q.dly[4:0], 8'h00};
          n.k = kk + 3'h1;
          n.st = (kk == DRAIN_LAST) ? ST_IDLE : ST_DRAIN;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign REG_RDATA_O = q.rdata;
  assign TX_EN_O = q.tx_en;
  assign TXD_O = q.txd;
  assign TX_STAMP_VALID_O = q.stamp_v;
  assign TX_STAMP_O = q.stamp;
  assign DELAY_RESP_INSERT_O = q.dr_ins;
  assign DELAY_REQ_STAMP_O = q.dreq;
  assign NTP_PORT_SELECT_O = q.ntp;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  rsvd_bit_a: assert property (REG_RDATA_O[14] == 1'b0)
    else $error("reserved bit reads one");
  ntp_follow_a: assert property (REG_WE_I && reg_hit(REG_PAGE_I, REG_ADDR_I) |-> ##2 NTP_PORT_SELECT_O == $past(REG_WDATA_I[12], 2))
    else $error("port select does not follow write");
  dresp_gate_a: assert property (DELAY_RESP_INSERT_O |-> $past(RX_STAMP_INSERT_EN_I) && $past(q.cfg.delay_request_stamp_insert))
    else $error("delay response insertion without receive enable");
  stamp_en_a: assert property (TX_STAMP_VALID_O |-> q.fcfg.transmit_stamp_enable && q.ok)
    else $error("stamp captured while disabled");
  ver_match_a: assert property (TX_STAMP_VALID_O |-> q.fcfg.transmit_version_match == 4'h0 || q.ver == q.fcfg.transmit_version_match)
    else $error("stamp for wrong version");
  dreq_keep_a: assert property (TX_STAMP_VALID_O && q.msg == MSG_DREQ |-> DELAY_REQ_STAMP_O == TX_STAMP_O)
    else $error("delay request stamp not updated");
  ins_sync_a: assert property ($rose(q.ins) |-> q.msg == MSG_SYNC && q.fcfg.sync_one_step_enable && (q.fcfg.ignore_two_step_flag || !q.two))
    else $error("insertion on wrong message");
  filt_ip_a: assert property (TX_STAMP_VALID_O && q.fcfg.iana_destination_filter && q.enc != ENC_L2 |-> q.dmatch)
    else $error("stamp for unassigned destination");
  l2_tail_a: assert property (q.st == ST_FRAME && !TX_EN_I && q.enc == ENC_L2 |=> TXD_O == $past(q.dly[5]))
    else $error("layer2 tail rewritten");
  crc_bad_a: assert property (q.st == ST_DRAIN && q.k == FIX_BYTES && q.ins && q.crc_in != CRC_RESIDUE &&
                              !q.fcfg.pass_valid_crc_on_insert |=> TXD_O == $past(q.crc_out[7:0]))
    else $error("bad check sequence not preserved");
  frame_len_a: assert property ($rose(TX_EN_I) && q.st == ST_IDLE |-> ##7 TX_EN_O)
    else $error("output does not start seven cycles later");

endmodule : pts_tx_stamp
`default_nettype wire

/* test/pts_mac_model.sv */
// Behavioural MAC that streams one whole frame per start request
`timescale 1ns/100ps
`default_nettype none
module pts_mac_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Frame request from the bench
  input wire logic start_i,
  input wire logic [7:0] frm_i [0:127],
  input wire logic [7:0] len_i,
  input wire logic [7:0] gap_i,
  output logic busy_o,
  // Byte stream toward the block
  output logic tx_en_o,
  output logic [7:0] txd_o
);
  logic [7:0] idx;

  // Idle data toggles so a stale byte never looks like a valid one
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      tx_en_o <= 1'b0;
      txd_o <= 8'h00;
      idx <= 8'h00;
    end else if (!busy_o) begin
      txd_o <= ~txd_o;
      if (start_i) begin
        busy_o <= 1'b1;
        tx_en_o <= 1'b1;
        txd_o <= frm_i[0];
        idx <= 8'h01;
      end
    end else if (idx < len_i) begin
      txd_o <= frm_i[idx];
      idx <= idx + 8'h01;
    end else begin
      // Busy covers the idle gap, so the next frame keeps its spacing
      tx_en_o <= 1'b0;
      txd_o <= ~txd_o;
      idx <= idx + 8'h01;
      if (idx == len_i + gap_i) busy_o <= 1'b0;
    end
  end
endmodule : pts_mac_model
`default_nettype wire

/* test/tb.sv */
// Register and frame regression for the transmit one-step stamp block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pts_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] page = 3'h0;
  logic [4:0] addr = 5'h00;
  logic we = 1'b0;
  logic rxen = 1'b0;
  logic start = 1'b0;
  logic mid = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] len = 8'h00;
  logic [7:0] gap = 8'h09;
  logic [15:0] rdata;
  logic mac_en, en_o, sv, dri, ntp, busy;
  logic [7:0] mac_d, txd_o, olen;
  logic [7:0] frm [0:127];
  logic [7:0] outb [0:127];
  pts_time_s tnow = '0;
  pts_time_s last_dreq = '0;
  pts_time_s tsq, drq;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int scnt = 0;

  pts_tx_stamp u_dut (.REF_CLK_I(clk), .NRST_I(nrst), .REG_PAGE_I(page), .REG_ADDR_I(addr), .REG_WE_I(we),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .TX_EN_I(mac_en), .TXD_I(mac_d), .TX_EN_O(en_o), .TXD_O(txd_o),
    .TIME_I(tnow), .TX_STAMP_VALID_O(sv), .TX_STAMP_O(tsq), .RX_STAMP_INSERT_EN_I(rxen),
    .DELAY_RESP_INSERT_O(dri), .DELAY_REQ_STAMP_O(drq), .NTP_PORT_SELECT_O(ntp));
  pts_mac_model u_mac (.clk_i(clk), .rst_n_i(nrst), .start_i(start), .frm_i(frm), .len_i(len), .gap_i(gap),
    .busy_o(busy), .tx_en_o(mac_en), .txd_o(mac_d));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Output capture and a ceiling well above the planned run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (en_o === 1'b1) begin
      outb[olen] = txd_o;
      olen = olen + 8'h01;
    end
    if (sv === 1'b1) scnt = scnt + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] pg, input logic [4:0] ad, input logic [15:0] d);
    @(posedge clk);
    page <= pg;
    addr <= ad;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] pg, input logic [4:0] ad, input logic [15:0] exp, input string nm);
    @(posedge clk);
    page <= pg;
    addr <= ad;
    repeat (2) @(posedge clk);
    #1 chk(nm, rdata, exp);
  endtask : rd

  function automatic logic [31:0] crc(input logic [7:0] a [0:127], input int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h000000, a[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc

  // Ones-complement sum; both zero encodings count as equal
  function automatic logic [15:0] sum16(input logic [7:0] a [0:127], input int s, input int e);
    logic [31:0] t;
    t = 32'h00000000;
    for (int i = s; i < e; i += 2) t = t + {a[i], a[i + 1]};
    t = t[15:0] + t[31:16];
    t = t[15:0] + t[31:16];
    return (t[15:0] == 16'hFFFF) ? 16'h0000 : t[15:0];
  endfunction : sum16

  task automatic run(input logic [15:0] cfg, input pts_enc_e enc, input logic [3:0] mt, input logic [7:0] ver,
      input logic [7:0] fl, input logic [15:0] port, input logic [7:0] dst, input logic bad, input int es,
      input int ei);
    int b, n, u;
    logic [31:0] c;
    logic fix;
    b = (enc == ENC_L2) ? BASE_L2 : (enc == ENC_V4) ? BASE_V4 : BASE_V6;
    n = b + 50;
    fix = (ei == 1) && cfg[9] && (enc != ENC_L2);
    for (int i = 0; i < 128; i++) frm[i] = 8'h00;
    {frm[12], frm[13]} = (enc == ENC_L2) ? ETYPE_L2 : (enc == ENC_V4) ? ETYPE_V4 : ETYPE_V6;
    frm[14] = 8'h45;
    if (enc == ENC_V4) {frm[23], frm[30], frm[31], frm[32], frm[33]} = {IP_UDP, V4_MCAST_HI, V4_MCAST_NEXT, 8'h01, dst};
    if (enc == ENC_V6) {frm[20], frm[38], frm[52], frm[53]} = {IP_UDP, V6_MCAST_HI, 8'h01, dst};
    if (enc != ENC_L2) {frm[b - 6], frm[b - 5]} = port;
    {frm[b], frm[b + 1], frm[b + 6]} = {4'h0, mt, ver, fl};
    c = ~crc(frm, n - 4);
    {frm[n - 1], frm[n - 2], frm[n - 3], frm[n - 4]} = c ^ (bad ? 32'h000000FF : 32'h00000000);
    len = n[7:0];
    gap = gap ^ 8'h07;
    wr(REG_PAGE_CFG, REG_ADDR_TXCFG, cfg);
    tnow <= {48'h000000123400 + cyc, 32'h1ABC0000 + cyc};
    olen = 8'h00;
    scnt = 0;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    // Clearing the settings while the frame is in flight must not touch that frame
    if (mid) wr(REG_PAGE_CFG, REG_ADDR_TXCFG, 16'h0000);
    for (int t = 0; t < 400 && busy !== 1'b0; t++) begin
      @(posedge clk);
      #1;
    end
    chk("length", olen, n);
    chk("ntp select", ntp, cfg[12]);
    chk("resp insert", dri, cfg[13] & rxen);
    if (es != 2) chk("stamp pulse", scnt, es);
    if (es == 1) chk("stamp value", tsq, tnow);
    if (es == 1 && mt == MSG_DREQ) last_dreq = tnow;
    chk("delay req stamp", drq, last_dreq);
    if (ei != 2) begin
      for (int i = 0; i < n - 4; i++) begin
        u = i - b - 34;
        if (!(fix && i >= n - 6)) chk("byte", outb[i], (ei == 1 && u >= 0 && u < 10) ?
          (tnow >> (8 * (9 - u))) & 80'hFF : frm[i]);
      end
      if (fix) chk("udp sum", sum16(outb, b - 8, n - 4), sum16(frm, b - 8, n - 4));
      chk("fcs ok", crc(outb, n) == CRC_RESIDUE, (ei == 1) ? (!bad || cfg[10]) : !bad);
    end
  endtask : run

  initial begin
    for (int i = 0; i < 128; i++) frm[i] = 8'h00;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(REG_PAGE_CFG, REG_ADDR_TXCFG, CFG_RST, "cfg reset");
    wr(REG_PAGE_CFG, REG_ADDR_TXCFG, 16'hFFFF);
    rd(REG_PAGE_CFG, REG_ADDR_TXCFG, 16'hBFFF, "cfg write");
    chk("resp insert off", dri, 1'b0);
    @(posedge clk);
    rxen <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("resp insert on", dri, 1'b1);
    wr(3'h4, REG_ADDR_TXCFG, 16'h0000);
    wr(REG_PAGE_CFG, 5'h17, 16'h0000);
    rd(REG_PAGE_CFG, REG_ADDR_TXCFG, 16'hBFFF, "cfg foreign write");
    rd(REG_PAGE_CFG, 5'h17, 16'h0000, "unmapped read");
    run(16'h82E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 1);
    run(16'h82E5, ENC_V6, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 1);
    run(16'h82E5, ENC_L2, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 1);
    run(16'h82E5, ENC_V4, MSG_SYNC, 8'h02, 8'h02, PORT_PTP, 8'h81, 1'b0, 2, 0);
    run(16'h8AE5, ENC_V4, MSG_SYNC, 8'h02, 8'h02, PORT_PTP, 8'h81, 1'b0, 1, 1);
    run(16'h82E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b1, 1, 1);
    run(16'h86E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b1, 1, 1);
    run(16'h82E5, ENC_V4, MSG_SYNC, 8'h03, 8'h00, PORT_PTP, 8'h81, 1'b0, 0, 0);
    run(16'h82E1, ENC_V4, MSG_SYNC, 8'h03, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 1);
    run(16'h82E4, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 0, 0);
    run(16'h8265, ENC_L2, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 0, 0);
    run(16'h83E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h82, 1'b0, 0, 0);
    run(16'h82E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h82, 1'b0, 1, 1);
    run(16'h92E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 0, 0);
    run(16'h92E1, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_NTP, 8'h81, 1'b0, 1, 2);
    run(16'h02E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 0);
    run(16'h80E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 1);
    run(16'hA2E5, ENC_V4, MSG_DREQ, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 0);
    run(16'h82E5, ENC_V6, MSG_DREQ, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 0);
    mid = 1'b1;
    run(16'h82E5, ENC_V4, MSG_SYNC, 8'h02, 8'h00, PORT_PTP, 8'h81, 1'b0, 1, 1);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
